// ### logic/nit_pkg.sv
/*
 * Shared constants of the nested interrupt unit: I/O addresses,
 * command word, source numbering, reset values and vector coding.
 * Assumes one processor clock domain and a 16-bit I/O write/read port.
 */
package nit_pkg;
    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int N_SRC = 14;
    localparam int IDX_W = 4;
    localparam int N_EXT = 6;
    localparam int N_TMR = 3;
    localparam int N_DMA = 2;
    localparam int N_SER = 2;
    localparam int IO_W = 16;

    // ----------------------------------------------------------------
    // I/O space map
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_END_CMD = 16'hFF22;
    localparam logic [15:0] ADDR_ENABLE = 16'hFF28;
    localparam logic [15:0] ADDR_IN_SERVICE = 16'hFF2C;
    localparam logic [15:0] ADDR_PENDING = 16'hFF2E;

    // ----------------------------------------------------------------
    // command word and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] END_CMD_NONSPECIFIC = 16'h8000;
    localparam logic [5:0] ENABLE_RESET = 6'h00;
    localparam logic [13:0] SRC_RESET = 14'h0000;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    // ----------------------------------------------------------------
    // source numbering, lowest index = highest priority
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_NMI = 4'h0;
    localparam int POS_TMR = 1;
    localparam int POS_DMA = 4;
    localparam int POS_EXT = 6;
    localparam int POS_SER = 12;

    // vector = base + source index
    localparam logic [7:0] VECTOR_BASE = 8'h20;
endpackage

// ### logic/nit_prio_pick.sv
/*
 * Fixed-priority picker: finds the lowest set index of a request vector.
 * Purely combinational; the caller registers what it needs.
 */
`timescale 1ns/1ns
`default_nettype none
module nit_prio_pick #(
    parameter int N = 14,
    parameter int W = 4
) (
    input wire logic [N-1:0] req,
    output logic valid,
    output logic [W-1:0] idx
);
    always_comb
    begin
        valid = 1'b0;
        idx = '0;
        // scan downward so the lowest set index wins
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                valid = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/nit_interrupt_control_unit.sv
/*
 * Interrupt control unit: six maskable external request lines, eight
 * internal sources (three timers, two DMA, two serial, watchdog NMI),
 * fully nested priority with in-service tracking, nonspecific end command.
 * Assumes all inputs synchronous to clock, a one-cycle io_wr / io_rd
 * strobe from the core, and int_ack pulsed once per taken request.
 */
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE_01 - six maskable external request pins accepted
// RULE_02 - eight internal sources without pins handled
// RULE_03 - external lines individually enabled, own vector
// RULE_04 - external lines masked after reset
// RULE_05 - highest pending first, higher preempts lower
// RULE_06 - handler clears in-service bit at end
// RULE_07 - word 0x8000 at 0xff22 clears top in-service
// RULE_08 - non-maskable request never blocked
module nit_interrupt_control_unit #(
    parameter int N_SRC = nit_pkg::N_SRC,
    parameter int IDX_W = nit_pkg::IDX_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [nit_pkg::N_EXT-1:0] ext_request,
    input wire logic [nit_pkg::N_TMR-1:0] timer_request,
    input wire logic [nit_pkg::N_DMA-1:0] dma_request,
    input wire logic [nit_pkg::N_SER-1:0] serial_request,
    input wire logic watchdog_nmi,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [15:0] io_rdata,
    output logic int_request,
    output logic [7:0] int_vector,
    input wire logic int_ack,
    output logic [N_SRC-1:0] in_service
);
    // ----------------------------------------------------------------
    // source gathering
    // ----------------------------------------------------------------
    logic [N_SRC-1:0] raw;
    logic [N_SRC-1:0] prev;
    logic [N_SRC-1:0] pending;
    logic [nit_pkg::N_EXT-1:0] ext_enable;
    logic [N_SRC-1:0] enable_all;
    logic [N_SRC-1:0] eligible;
    logic [N_SRC-1:0] rise;
    logic [N_SRC-1:0] ack_clear;
    logic [N_SRC-1:0] end_clear;
    logic [IDX_W-1:0] ack_idx;

    // fixed placement: nmi, timers, dma, external lines, serial ports
    assign raw = {serial_request, ext_request, dma_request, timer_request,
                  watchdog_nmi}; // RULE_01 RULE_02
    assign rise = raw & ~prev;

    // only the external lines carry an enable; internal ones always on
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++)
        begin : g_enable
            if (g >= nit_pkg::POS_EXT && g < nit_pkg::POS_EXT + nit_pkg::N_EXT)
            begin : g_ext
                assign enable_all[g] = ext_enable[g - nit_pkg::POS_EXT]; // RULE_03
            end
            else
            begin : g_int
                assign enable_all[g] = 1'b1; // RULE_08
            end
        end
    endgenerate

    assign eligible = pending & enable_all;

    // ----------------------------------------------------------------
    // priority resolution
    // ----------------------------------------------------------------
    logic cand_valid;
    logic [IDX_W-1:0] cand_idx;
    logic isv_valid;
    logic [IDX_W-1:0] isv_idx;
    logic deliver;

    nit_prio_pick #(
        .N(N_SRC),
        .W(IDX_W)
    ) u_pick_pending (
        .req(eligible),
        .valid(cand_valid),
        .idx(cand_idx)
    );

    nit_prio_pick #(
        .N(N_SRC),
        .W(IDX_W)
    ) u_pick_service (
        .req(in_service),
        .valid(isv_valid),
        .idx(isv_idx)
    );

    // strictly higher priority preempts; nmi passes regardless
    assign deliver = cand_valid && (!isv_valid || (cand_idx < isv_idx)
                     || (cand_idx == nit_pkg::IDX_NMI)); // RULE_05 RULE_08

    // ----------------------------------------------------------------
    // I/O decode
    // ----------------------------------------------------------------
    logic end_cmd_write;

    function automatic logic io_hit(input logic [15:0] a, input logic [15:0] ref_addr);
        io_hit = (a == ref_addr);
    endfunction

    assign end_cmd_write = io_wr && io_hit(io_addr, nit_pkg::ADDR_END_CMD)
                           && (io_wdata == nit_pkg::END_CMD_NONSPECIFIC); // RULE_07 RULE_06

    always_comb
    begin
        ack_clear = '0;
        end_clear = '0;
        if (int_ack)
        begin
            ack_clear[ack_idx] = 1'b1;
        end
        if (end_cmd_write && isv_valid)
        begin
            end_clear[isv_idx] = 1'b1; // RULE_07
        end
    end

    // ----------------------------------------------------------------
    // request latches
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            prev <= nit_pkg::SRC_RESET;
        end
        else
        begin
            prev <= raw;
        end
    end

    // a fresh edge in the ack cycle survives: set beats clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pending <= nit_pkg::SRC_RESET;
        end
        else
        begin
            pending <= (pending & ~ack_clear) | rise; // RULE_01 RULE_02
        end
    end

    // ----------------------------------------------------------------
    // enable register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ext_enable <= nit_pkg::ENABLE_RESET; // RULE_04
        end
        else if (io_wr && io_hit(io_addr, nit_pkg::ADDR_ENABLE))
        begin
            ext_enable <= io_wdata[nit_pkg::N_EXT-1:0]; // RULE_03 RULE_04
        end
    end

    // ----------------------------------------------------------------
    // in-service tracking
    // ----------------------------------------------------------------
    // ack sets, end command clears; same bit in one cycle keeps it set
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            in_service <= nit_pkg::SRC_RESET;
        end
        else
        begin
            in_service <= (in_service & ~end_clear) | ack_clear; // RULE_05 RULE_07
        end
    end

    // ----------------------------------------------------------------
    // processor side
    // ----------------------------------------------------------------
    // request drops for one cycle after ack so a stale winner is
    // never offered twice
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            int_request <= 1'b0;
        end
        else
        begin
            int_request <= deliver && !int_ack; // RULE_05 RULE_08
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ack_idx <= '0;
            int_vector <= nit_pkg::VECTOR_BASE;
        end
        else if (deliver && !int_ack)
        begin
            ack_idx <= cand_idx;
            int_vector <= nit_pkg::VECTOR_BASE + 8'(cand_idx); // RULE_03
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // end command is write-only and unmapped addresses answer zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            io_rdata <= nit_pkg::RDATA_IDLE;
        end
        else if (io_rd)
        begin
            if (io_hit(io_addr, nit_pkg::ADDR_ENABLE))
            begin
                io_rdata <= 16'(ext_enable);
            end
            else if (io_hit(io_addr, nit_pkg::ADDR_IN_SERVICE))
            begin
                io_rdata <= 16'(in_service);
            end
            else if (io_hit(io_addr, nit_pkg::ADDR_PENDING))
            begin
                io_rdata <= 16'(pending);
            end
            else
            begin
                io_rdata <= nit_pkg::RDATA_IDLE;
            end
        end
        else
        begin
            io_rdata <= nit_pkg::RDATA_IDLE;
        end
    end
endmodule
`default_nettype wire

// ### dv/nit_core_model.sv
/* core-side partner: takes offered requests, promptly or after a wait.
   assumes int_request stands until int_ack is seen. */
`timescale 1ns/1ns
`default_nettype none
module nit_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic int_request,
    input wire logic [7:0] int_vector,
    input wire logic slow,
    output logic int_ack,
    output logic [7:0] taken_vector,
    output logic [7:0] n_taken
);
    logic [2:0] delay = 3'h0;
    initial
    begin
        int_ack = 1'b0;
        taken_vector = 8'h00;
        n_taken = 8'h00;
    end
    // one ack pulse per offer, never while nothing is offered
    always @(posedge clock)
    begin
        #1;
        delay = int_request ? delay + 3'h1 : 3'h0;
        if (int_ack || rst)
            int_ack = 1'b0;
        else if (int_request && (!slow || delay > 3'h3))
        begin
            int_ack = 1'b1;
            taken_vector = int_vector;
            n_taken = n_taken + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### dv/nit_checker.sv
/* port-level assertions of the interrupt unit.
   assumes the top module's ports only; bound below. */
`timescale 1ns/1ns
`default_nettype none
module nit_checker #(
    parameter int N_SRC = 14
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic watchdog_nmi,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_rdata,
    input wire logic int_request,
    input wire logic [7:0] int_vector,
    input wire logic int_ack,
    input wire logic [N_SRC-1:0] in_service
);
    logic end_cmd;
    // an ack in the same cycle may set a bit, so it is left out
    assign end_cmd = io_wr && io_addr == 16'hFF22 && !int_ack;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_ack_drop;
        int_ack && int_request |=> !int_request;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
    property p_ack_sets;
        int_ack && int_request |=> in_service[$past(int_vector[3:0])];
    endproperty
    a_ack_sets: assert property (p_ack_sets) else $error("ack left bit clear");
    property p_hold;
        int_request && !int_ack |=> int_request && $stable(int_vector);
    endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ack");
    property p_vector;
        int_request |-> int_vector inside {[8'h20:8'h2D]};
    endproperty
    a_vector: assert property (p_vector) else $error("vector out of range");
    property p_nest;
        int_request && int_vector != 8'h20 |-> (in_service << (4'hD - int_vector[3:0])) == '0;
    endproperty
    a_nest: assert property (p_nest) else $error("offer not above service");
    property p_nmi;
        $rose(watchdog_nmi) |-> ##[2:24] int_request && int_vector == 8'h20;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not offered");
    property p_end_cmd;
        end_cmd && io_wdata == 16'h8000
        |=> in_service == ($past(in_service) & ($past(in_service) - 1'b1));
    endproperty
    a_end_cmd: assert property (p_end_cmd) else $error("end command cleared wrong bit");
    property p_end_word;
        end_cmd && io_wdata != 16'h8000 |=> $stable(in_service);
    endproperty
    a_end_word: assert property (p_end_word) else $error("other word changed service");
    property p_wo_read;
        io_rd && io_addr == 16'hFF22 |=> io_rdata == 16'h0000;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("command register readable");
endmodule
bind nit_interrupt_control_unit nit_checker #(.N_SRC(N_SRC)) i_checker (
    .clock(clock), .rst(rst), .watchdog_nmi(watchdog_nmi), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .int_request(int_request), .int_vector(int_vector), .int_ack(int_ack),
    .in_service(in_service)
);
`default_nettype wire

// ### dv/test_nested_interrupt_unit.sv
/* self-checking bench of the interrupt unit with a core-side model.
   assumes sources indexed by priority, as the unit numbers them. */
`timescale 1ns/1ns
`default_nettype none
module test_nested_interrupt_unit;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [13:0] src = 14'h0000;
    logic [15:0] io_addr = 16'h0000;
    logic [15:0] io_wdata = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic slow = 1'b0;
    logic [15:0] io_rdata;
    logic int_request;
    logic [7:0] int_vector;
    logic int_ack;
    logic [13:0] in_service;
    logic [7:0] taken_vector;
    logic [7:0] n_taken;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int srcs[7] = '{1, 2, 3, 4, 5, 12, 13};
    always #5 clock = ~clock;
    nit_interrupt_control_unit i_dut (
        .clock(clock), .rst(rst), .ext_request(src[11:6]), .timer_request(src[3:1]),
        .dma_request(src[5:4]), .serial_request(src[13:12]), .watchdog_nmi(src[0]),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .int_request(int_request), .int_vector(int_vector),
        .int_ack(int_ack), .in_service(in_service)
    );
    nit_core_model i_core (
        .clock(clock), .rst(rst), .int_request(int_request), .int_vector(int_vector),
        .slow(slow), .int_ack(int_ack), .taken_vector(taken_vector), .n_taken(n_taken)
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // each access ends with an idle edge so the next strobe never meets this release
    task automatic io_write(input logic [15:0] a, input logic [15:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        step(1);
        io_wr = 1'b0;
        step(1);
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [15:0] exp);
        io_addr = a;
        io_rd = 1'b1;
        step(1);
        io_rd = 1'b0;
        check(io_rdata, exp);
        step(1);
    endtask
    task automatic end_service();
        io_write(16'hFF22, 16'h8000);
    endtask
    task automatic pulse(input int i);
        src[i] = 1'b1;
        step(1);
        src[i] = 1'b0;
    endtask
    // waits for one more ack, lets the ack edge pass, then compares count and vector
    task automatic await(input logic [7:0] k, input logic [7:0] vec);
        repeat (24) if (n_taken == k) step(1);
        step(1);
        check({n_taken - k, taken_vector}, {8'h01, vec});
    endtask
    // count taken before the write, as the offer may be acked inside it
    task automatic write_take(input logic [15:0] a, input logic [15:0] d, input logic [7:0] vec);
        logic [7:0] k;
        k = n_taken;
        io_write(a, d);
        await(k, vec);
    endtask
    task automatic take(input int i, input logic [7:0] vec);
        logic [7:0] k;
        k = n_taken;
        pulse(i);
        await(k, vec);
    endtask
    task automatic none(input int i);
        logic [7:0] k;
        k = n_taken;
        pulse(i);
        step(12);
        check({8'h00, n_taken - k}, 16'h0000);
    endtask
    task automatic test_reset();
        rd_check(16'hFF28, 16'h0000);
        rd_check(16'hFF2C, 16'h0000);
        rd_check(16'hFF22, 16'h0000);
        $display("test_reset done");
    endtask
    task automatic test_mask();
        none(6);
        rd_check(16'hFF2E, 16'h0040);
        write_take(16'hFF28, 16'hFFFF, 8'h26);
        rd_check(16'hFF28, 16'h003F);
        rd_check(16'hFF2C, 16'h0040);
        end_service();
        rd_check(16'hFF2C, 16'h0000);
        io_write(16'hFF28, 16'h0000);
        none(7);
        write_take(16'hFF28, 16'h0002, 8'h27);
        end_service();
        $display("test_mask done");
    endtask
    task automatic test_nest();
        slow = 1'b1;
        io_write(16'hFF28, 16'h003F);
        take(11, 8'h2B);
        take(6, 8'h26);
        rd_check(16'hFF2C, 16'h0840);
        check({2'b00, in_service}, 16'h0840);
        none(10);
        end_service();
        await(n_taken, 8'h2A);
        rd_check(16'hFF2C, 16'h0C00);
        io_write(16'hFF22, 16'h1234);
        rd_check(16'hFF2C, 16'h0C00);
        end_service();
        end_service();
        rd_check(16'hFF2C, 16'h0000);
        slow = 1'b0;
        $display("test_nest done");
    endtask
    task automatic test_internal();
        foreach (srcs[i])
        begin
            take(srcs[i], 8'h20 + 8'(srcs[i]));
            end_service();
        end
        take(6, 8'h26);
        io_write(16'hFF28, 16'h0000);
        take(0, 8'h20);
        rd_check(16'hFF2C, 16'h0041);
        check({2'b00, in_service}, 16'h0041);
        end_service();
        end_service();
        rd_check(16'hFF2C, 16'h0000);
        $display("test_internal done");
    endtask
    // run is some 200 cycles, the ceiling leaves ample room
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        step(5);
        rst = 1'b0;
        test_reset();
        test_mask();
        test_nest();
        test_internal();
        complete_run();
    end
endmodule
`default_nettype wire
